// [pkg/loader_pkg.sv]
// Constants, types and default tables shared by the register default loader
`default_nettype none
package loader_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Non-volatile store layout
  localparam int          NVM_SIZE     = 8192;
  localparam logic [12:0] NVM_DEF_BASE = 13'h0040;
  localparam logic [12:0] RSP_TX_BASE  = 13'h1C00;
  localparam logic [12:0] RSP_RX_BASE  = 13'h1E00;

  ////////////////////////////////////////////////////////////////////////////
  // Register file and copy windows
  localparam int         REG_COUNT    = 64;
  localparam logic [5:0] DEF_LAST     = 6'h3F;
  localparam logic [5:0] TX_LAST      = 6'h0F;
  localparam logic [5:0] RX_LAST      = 6'h07;
  localparam logic [5:0] TX_DST_BASE  = 6'h28;
  localparam logic [5:0] RX_DST_BASE  = 6'h38;

  ////////////////////////////////////////////////////////////////////////////
  // Host map beyond the register file
  localparam logic [7:0] A_LDR_CMD    = 8'h40;
  localparam logic [7:0] A_TX_PROTO   = 8'h41;
  localparam logic [7:0] A_RX_PROTO   = 8'h42;
  localparam logic [7:0] A_NVM_LO     = 8'h43;
  localparam logic [7:0] A_NVM_HI     = 8'h44;
  localparam logic [7:0] A_NVM_DATA   = 8'h45;
  localparam logic [7:0] CMD_REG_LOAD = 8'h01;
  localparam logic [7:0] CMD_PROTO_LD = 8'h02;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DEF  = 2'b01,
    ST_TX   = 2'b10,
    ST_RX   = 2'b11
  } load_state_type;

  ////////////////////////////////////////////////////////////////////////////
  // Factory image of the register reset section; unlisted bytes are zero
  function automatic logic [7:0] factory_default(input logic [5:0] idx);
    logic [7:0] v;
    case (idx)
      6'h00: v = 8'h40;
      6'h02: v = 8'h80;
      6'h03: v = 8'h05;
      6'h08: v = 8'h10;
      6'h11, 6'h16, 6'h1B, 6'h20, 6'h25: v = 8'h80;
      6'h28: v = 8'h86;
      6'h29: v = 8'h15;
      6'h2A: v = 8'h11;
      6'h2B: v = 8'h06;
      6'h2C, 6'h2D: v = 8'h18;
      6'h2E: v = 8'h08;
      6'h2F: v = 8'h27;
      6'h31: v = 8'hC0;
      6'h32: v = 8'h12;
      6'h33: v = 8'hCF;
      6'h35: v = 8'h04;
      6'h36: v = 8'h90;
      6'h37: v = 8'h3F;
      6'h38: v = 8'h12;
      6'h39: v = 8'h0A;
      6'h3B: v = 8'h7A;
      6'h3C: v = 8'h80;
      6'h3D: v = 8'h04;
      6'h3E: v = 8'h20;
      6'h3F: v = 8'h48;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Bits that a load may write; read-only counters, status and spare stay put
  function automatic logic [7:0] load_mask(input logic [5:0] idx);
    logic [7:0] m;
    case (idx)
      6'h04, 6'h0A, 6'h0B, 6'h12, 6'h13, 6'h17, 6'h18: m = 8'h00;
      6'h1C, 6'h1D, 6'h21, 6'h22, 6'h26, 6'h27, 6'h3A: m = 8'h00;
      default: m = 8'hFF;
    endcase
    return m;
  endfunction

endpackage
`default_nettype wire

// [pkg/nvm_port_if.sv]
// Byte port between the loader and its non-volatile store
`timescale 1ns/10ps
`default_nettype none
interface nvm_port_if;
  logic [12:0] addr;
  logic [7:0]  wdata;
  logic        we;
  logic [7:0]  rdata;
  modport ctrl (output addr, output wdata, output we, input rdata);
  modport mem  (input addr, input wdata, input we, output rdata);
endinterface
`default_nettype wire

// [hw/nvm_store.sv]
// Non-volatile byte store holding register defaults and protocol settings
`timescale 1ns/10ps
`default_nettype none
module nvm_store
  import loader_pkg::*;
  #(parameter int NVM_DEPTH = NVM_SIZE)
  (input wire logic mclk,
   input wire logic rst,
   nvm_port_if.mem  port);

  if (NVM_DEPTH != NVM_SIZE) begin : g_depth_chk
    $error("nvm_store depth must match the fixed section layout");
  end

  logic [7:0] mem [NVM_DEPTH];

  // Content survives rst; only the power-up image is preset
  initial begin
    for (int i = 0; i < NVM_DEPTH; i++) begin
      mem[i] = 8'h00;
    end
    for (int j = 0; j < REG_COUNT; j++) begin
      mem[int'(NVM_DEF_BASE) + j] = factory_default(6'(j));
    end
  end

  always @(posedge mclk) begin
    if (port.we) begin
      mem[port.addr] <= port.wdata;
    end
  end

  assign port.rdata = mem[port.addr];

  nvm_write_a: assert property (@(posedge mclk) disable iff (rst)
    port.we |=> mem[$past(port.addr)] == $past(port.wdata))
    else $error("stored byte differs from written byte");

endmodule
`default_nettype wire

// [hw/eeprom_register_default_loader.sv]
// Register default loader: startup and command copies from non-volatile store
//
// Functional notes
// - Startup copies stored defaults into registers
// - Copy touches only read/write and dynamic bits
// - Protocol source addresses selectable by user
// - Host may rewrite stored defaults for restart
// - Protocol load command copies protocol settings
// - Factory image holds documented reset values
// - Register load command repeats default copy
// - Protocol entries: 16 transmit, 8 receive bytes
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module eeprom_register_default_loader
  import loader_pkg::*;
  #(parameter int NVM_DEPTH = NVM_SIZE)
  (input  wire logic                   mclk,
   input  wire logic                   rst,
   input  wire logic [7:0]             addr,
   input  wire logic [7:0]             wr_data,
   input  wire logic                   wr_stb,
   input  wire logic                   rd_stb,
   output logic      [7:0]             rd_data,
   output logic                        busy,
   output logic      [REG_COUNT*8-1:0] reg_image);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [12:0] copy_source(input load_state_type st,
                                              input logic [5:0]     c,
                                              input logic [4:0]     txp,
                                              input logic [5:0]     rxp);
    logic [12:0] src;
    case (st)
      ST_DEF:  src = NVM_DEF_BASE + {7'h00, c};
      ST_TX:   src = RSP_TX_BASE + {4'h0, txp, c[3:0]};
      ST_RX:   src = RSP_RX_BASE + {4'h0, rxp, c[2:0]};
      default: src = NVM_DEF_BASE;
    endcase
    return src;
  endfunction

  function automatic logic [5:0] copy_target(input load_state_type st,
                                             input logic [5:0]     c);
    logic [5:0] dst;
    case (st)
      ST_DEF:  dst = c;
      ST_TX:   dst = TX_DST_BASE + {2'b00, c[3:0]};
      ST_RX:   dst = RX_DST_BASE + {3'b000, c[2:0]};
      default: dst = 6'h00;
    endcase
    return dst;
  endfunction

  function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic [7:0] m);
    return (old_v & ~m) | (new_v & m);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  load_state_type              state_reg;
  load_state_type              state_next;
  logic [5:0]                  cnt_reg;
  logic [5:0]                  cnt_next;
  logic                        busy_reg;
  logic [REG_COUNT-1:0][7:0]   regs_reg;
  logic [4:0]                  tx_proto_reg;
  logic [5:0]                  rx_proto_reg;
  logic [12:0]                 nvm_addr_reg;
  logic [12:0]                 nvm_addr_next;
  logic [7:0]                  rd_data_reg;
  logic [6:0]                  busy_cycles_reg;
  logic                        nvm_touched_reg;

  nvm_port_if nvm_bus ();

  nvm_store #(.NVM_DEPTH(NVM_DEPTH)) u_store (
    .mclk (mclk),
    .rst  (rst),
    .port (nvm_bus.mem)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Host decode; everything but the status read is refused while busy

  wire       copying   = (state_reg != ST_IDLE);
  wire       host_wr   = wr_stb && !busy_reg;
  wire       hit_reg   = (addr[7:6] == 2'b00);
  wire       sel_cmd   = (addr == A_LDR_CMD);
  wire       sel_txp   = (addr == A_TX_PROTO);
  wire       sel_rxp   = (addr == A_RX_PROTO);
  wire       sel_alo   = (addr == A_NVM_LO);
  wire       sel_ahi   = (addr == A_NVM_HI);
  wire       sel_data  = (addr == A_NVM_DATA);
  wire       rd_ok     = rd_stb && (!busy_reg || sel_cmd);
  wire       cmd_reg   = host_wr && sel_cmd && (wr_data == CMD_REG_LOAD);
  wire       cmd_proto = host_wr && sel_cmd && (wr_data == CMD_PROTO_LD);
  wire       nvm_wr    = host_wr && sel_data;

  wire       copy_last = ((state_reg == ST_DEF) && (cnt_reg == DEF_LAST)) ||
                         ((state_reg == ST_TX) && (cnt_reg == TX_LAST)) ||
                         ((state_reg == ST_RX) && (cnt_reg == RX_LAST));

  wire [5:0] copy_dst  = copy_target(state_reg, cnt_reg);
  wire       reg_we    = copying || (host_wr && hit_reg);
  wire [5:0] wr_idx    = copying ? copy_dst : addr[5:0];
  wire [7:0] wr_val    = copying ? nvm_bus.rdata : wr_data;
  wire [7:0] wr_merged = merge_byte(regs_reg[wr_idx], wr_val, load_mask(wr_idx));

  wire [7:0] rd_value  = hit_reg  ? regs_reg[addr[5:0]] :
                         sel_cmd  ? {7'h00, busy_reg} :
                         sel_txp  ? {3'b000, tx_proto_reg} :
                         sel_rxp  ? {2'b00, rx_proto_reg} :
                         sel_alo  ? nvm_addr_reg[7:0] :
                         sel_ahi  ? {3'b000, nvm_addr_reg[12:8]} :
                         sel_data ? nvm_bus.rdata : 8'h00;

  // Protocol index picks the source entry in the protocol area
  assign nvm_bus.addr  = copying ? copy_source(state_reg, cnt_reg, tx_proto_reg, rx_proto_reg)
                                 : nvm_addr_reg;
  assign nvm_bus.wdata = wr_data;
  assign nvm_bus.we    = nvm_wr;

  // Writes auto-increment so a whole entry streams in with one address set
  assign nvm_addr_next = sel_alo  ? {nvm_addr_reg[12:8], wr_data} :
                         sel_ahi  ? {wr_data[4:0], nvm_addr_reg[7:0]} :
                         sel_data ? nvm_addr_reg + 13'h0001 : nvm_addr_reg;

  assign cnt_next = (!copying || copy_last) ? 6'h00 : cnt_reg + 6'h01;

  ////////////////////////////////////////////////////////////////////////////
  // Load sequencer

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (cmd_reg) begin
          state_next = ST_DEF;
        end else if (cmd_proto) begin
          state_next = ST_TX;
        end
      end
      ST_DEF: begin
        if (copy_last) begin
          state_next = ST_IDLE;
        end
      end
      ST_TX: begin
        if (copy_last) begin
          state_next = ST_RX;
        end
      end
      ST_RX: begin
        if (copy_last) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // Reset lands in the default copy, so release of rst is the startup load
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= ST_DEF;
      cnt_reg   <= 6'h00;
      busy_reg  <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      busy_reg  <= (state_next != ST_IDLE);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      regs_reg <= '0;
    end else if (reg_we) begin
      regs_reg[wr_idx] <= wr_merged;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host registers

  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_proto_reg <= 5'h00;
      rx_proto_reg <= 6'h00;
      nvm_addr_reg <= 13'h0000;
    end else if (host_wr) begin
      if (sel_txp) begin
        tx_proto_reg <= wr_data[4:0];
      end
      if (sel_rxp) begin
        rx_proto_reg <= wr_data[5:0];
      end
      nvm_addr_reg <= nvm_addr_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_data_reg <= 8'h00;
    end else begin
      rd_data_reg <= rd_ok ? rd_value : 8'h00;
    end
  end

  assign rd_data   = rd_data_reg;
  assign busy      = busy_reg;
  assign reg_image = regs_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  always_ff @(posedge mclk) begin
    if (rst || !copying) begin
      busy_cycles_reg <= 7'h00;
    end else begin
      busy_cycles_reg <= busy_cycles_reg + 7'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      nvm_touched_reg <= 1'b0;
    end else if (nvm_wr) begin
      nvm_touched_reg <= 1'b1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  startup_copy_a: assert property ($fell(rst) |->
    state_reg == ST_DEF && busy_reg && cnt_reg == 6'h00)
    else $error("startup copy did not begin at reset release");

  ro_bits_kept_a: assert property (copying |=>
    ((regs_reg[$past(wr_idx)] ^ $past(regs_reg[wr_idx])) & ~load_mask($past(wr_idx))) == 8'h00)
    else $error("load changed a protected bit");

  proto_source_a: assert property ($rose(state_reg == ST_TX) |->
    nvm_bus.addr == RSP_TX_BASE + {4'h0, tx_proto_reg, 4'h0})
    else $error("protocol load read the wrong entry");

  proto_cmd_a: assert property (cmd_proto |=>
    state_reg == ST_TX && busy_reg && cnt_reg == 6'h00)
    else $error("protocol load command not started");

  factory_image_a: assert property (
    ($past(state_reg) == ST_DEF && state_reg == ST_IDLE && !nvm_touched_reg) |->
    regs_reg[0] == 8'h40 && regs_reg[2] == 8'h80 && regs_reg[3] == 8'h05 &&
    regs_reg[8] == 8'h10 && regs_reg[17] == 8'h80 && regs_reg[44] == 8'h18 &&
    regs_reg[45] == 8'h18)
    else $error("factory defaults not applied");

  reg_cmd_a: assert property (cmd_reg |=>
    state_reg == ST_DEF ##64 (state_reg == ST_IDLE && !busy_reg))
    else $error("register load did not take 64 cycles");

  proto_len_a: assert property ((state_reg == ST_RX && copy_last) |->
    busy_cycles_reg == 7'd23)
    else $error("protocol load length wrong");

  copy_value_a: assert property (copying |=>
    (regs_reg[$past(wr_idx)] & load_mask($past(wr_idx))) ==
    ($past(nvm_bus.rdata) & load_mask($past(wr_idx))))
    else $error("copied byte differs from stored byte");

  def_len_a: assert property ((state_reg == ST_DEF && copy_last) |->
    busy_cycles_reg == 7'd63)
    else $error("default copy length wrong");

  busy_refuse_a: assert property ((rd_stb && busy_reg && !sel_cmd) |=>
    rd_data == 8'h00)
    else $error("read answered while loading");

  startup_done_c: cover property ($fell(busy_reg) && !nvm_touched_reg);
  proto_done_c: cover property (state_reg == ST_RX && copy_last);
  nvm_edit_reload_c: cover property (nvm_touched_reg && cmd_reg);

endmodule
`default_nettype wire

// [dv/nvm_shadow_model.sv]
// Shadow of the non-volatile store, mirrored from host window writes
`timescale 1ns/10ps
`default_nettype none
module nvm_shadow_model
  import loader_pkg::*;
  (input wire logic       mclk,
   input wire logic [7:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic       wr_stb,
   input wire logic       busy);

  logic [7:0]  mem [NVM_SIZE];
  logic [12:0] ptr = 13'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Stored bytes survive reset, so nothing here is cleared
  always @(posedge mclk) begin
    if (wr_stb === 1'b1 && busy === 1'b0) begin
      case (addr)
        A_NVM_LO: ptr[7:0] <= wr_data;
        A_NVM_HI: ptr[12:8] <= wr_data[4:0];
        A_NVM_DATA: begin
          mem[ptr] <= wr_data;
          ptr      <= ptr + 13'h0001;
        end
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

// [dv/tb.sv]
// Self-checking bench for the register default loader
`timescale 1ns/10ps
`default_nettype none
module tb
  import loader_pkg::*;
  ;
  logic                   mclk;
  logic                   rst;
  logic [7:0]             addr;
  logic [7:0]             wr_data;
  logic                   wr_stb;
  logic                   rd_stb;
  logic [7:0]             rd_data;
  logic                   busy;
  logic [REG_COUNT*8-1:0] reg_image;
  int                     err_count;
  int                     check_count;
  logic [5:0]             def_idx [11] = '{6'h00, 6'h02, 6'h03, 6'h08, 6'h11, 6'h16, 6'h1b, 6'h20, 6'h25, 6'h2c, 6'h2d};
  logic [7:0]             def_val [11] = '{8'h40, 8'h80, 8'h05, 8'h10, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h18, 8'h18};

  eeprom_register_default_loader DUT (.mclk(mclk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
                                      .rd_stb(rd_stb), .rd_data(rd_data), .busy(busy), .reg_image(reg_image));
  nvm_shadow_model nvm_model (.mclk(mclk), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .busy(busy));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (err_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask

  function automatic logic [7:0] img(input int i);
    return reg_image[i*8 +: 8];
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr    <= a;
    wr_data <= d;
    wr_stb  <= 1'b1;
    @(posedge mclk);
    wr_stb  <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    @(negedge mclk);
    d = rd_data;
  endtask

  // Counts cycles with busy high; bounded so a stuck copy cannot hang here
  task automatic wait_idle(output int n);
    n = 0;
    @(negedge mclk);
    while (busy === 1'b1 && n < 1000) begin
      n++;
      @(negedge mclk);
    end
  endtask

  task automatic nvm_fill(input logic [12:0] base, input logic [7:0] d, input int cnt);
    wr(A_NVM_LO, base[7:0]);
    wr(A_NVM_HI, {3'b000, base[12:8]});
    for (int i = 0; i < cnt; i++) begin
      wr(A_NVM_DATA, d + 8'(i));
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_startup();
    logic [7:0] d;
    int         n;
    repeat (10) @(posedge mclk);
    rd(8'h00, d);
    chk("read while busy", 8'h00, d);
    rd(A_LDR_CMD, d);
    chk("busy poll", 8'h01, d);
    // Byte 1 is already copied by now, so only a refused write keeps it zero
    wr(8'h01, 8'hee);
    wait_idle(n);
    chk("startup copy ends", 8'h01, (n < 100) ? 8'h01 : 8'h00);
    for (int i = 0; i < 11; i++) begin
      chk("factory default", def_val[i], img(int'(def_idx[i])));
    end
    chk("write while busy", 8'h00, img(1));
  endtask

  task automatic t_host_rw();
    logic [7:0] d;
    wr(8'h02, 8'hab);
    rd(8'h02, d);
    chk("register readback", 8'hab, d);
    @(negedge mclk);
    chk("read data released", 8'h00, rd_data);
    wr(8'h04, 8'hff);
    @(negedge mclk);
    chk("read-only register", 8'h00, img(4));
  endtask

  task automatic t_proto();
    int         n;
    logic [7:0] e;
    wr(A_TX_PROTO, 8'h03);
    wr(A_RX_PROTO, 8'h05);
    rd(A_TX_PROTO, e);
    chk("transmit protocol index", 8'h03, e);
    rd(A_RX_PROTO, e);
    chk("receive protocol index", 8'h05, e);
    nvm_fill(RSP_TX_BASE + 13'd48, 8'ha0, 16);
    nvm_fill(RSP_RX_BASE + 13'd40, 8'hc0, 8);
    wr(A_LDR_CMD, CMD_PROTO_LD);
    wait_idle(n);
    chk("protocol load length", 8'd24, 8'(n));
    for (int i = 0; i < 16; i++) begin
      chk("transmit settings", nvm_model.mem[RSP_TX_BASE + 13'd48 + 13'(i)], img(int'(TX_DST_BASE) + i));
    end
    for (int i = 0; i < 8; i++) begin
      e = (int'(RX_DST_BASE) + i == 8'h3a) ? 8'h00 : nvm_model.mem[RSP_RX_BASE + 13'd40 + 13'(i)];
      chk("receive settings", e, img(int'(RX_DST_BASE) + i));
    end
  endtask

  // Edits stored defaults, reloads by command, then by a fresh startup
  task automatic t_reg_load();
    logic [7:0] d;
    int         n;
    nvm_fill(NVM_DEF_BASE + 13'd2, 8'h5a, 3);
    wr(A_NVM_LO, 8'h43);
    rd(A_NVM_DATA, d);
    chk("stored default readback", nvm_model.mem[13'h0043], d);
    wr(8'h02, 8'h00);
    wr(A_LDR_CMD, CMD_REG_LOAD);
    wait_idle(n);
    chk("register load length", 8'd64, 8'(n));
    chk("reloaded byte 2", nvm_model.mem[13'h0042], img(2));
    chk("reloaded byte 3", nvm_model.mem[13'h0043], img(3));
    chk("masked byte 4", 8'h00, img(4));
    chk("factory byte 0", 8'h40, img(0));
    @(posedge mclk);
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    wait_idle(n);
    chk("edited default at startup", 8'h5a, img(2));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst         = 1'b1;
    addr        = 8'h00;
    wr_data     = 8'h00;
    wr_stb      = 1'b0;
    rd_stb      = 1'b0;
    err_count   = 0;
    check_count = 0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    t_startup();
    t_host_rw();
    t_proto();
    t_reg_load();
    stop_test();
  end

  // Whole run needs a few hundred cycles; this bound leaves ample margin
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    stop_test();
  end
endmodule
`default_nettype wire
